/* File: bench/rtx_exec_bench.sv */
// Purpose: self-checking bench for the register transfer execute block
// Assumes: rows run back to back; a bench model tracks every register
// Notes: ram starts unknown, so acc is compared only once the model knows it
`timescale 1ns/1ps
module rtx_exec_bench;
    import rtx_pkg::*;
    logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_exec = 1'b0;
    logic [RTX_OPW-1:0] i_opcode = '0;
    logic i_carry_flag = 1'b0, i_z_we = 1'b0;
    logic [1:0] i_z_ld = 2'h0;
    logic [3:0] o_acc, o_b, o_x, o_y, m_a, m_b, m_x, m_y;
    logic [7:0] o_e, m_e;
    logic [2:0] o_d, m_d;
    logic [1:0] o_z, m_z;
    logic o_carry_flag, o_skip, m_s;
    logic [3:0] m_ram [0:1023];
    int fails = 0, compares = 0;
    localparam logic [9:0] rows [0:17] = '{10'h053, 10'h00e, 10'h00c,
        10'h2e5, 10'h01e, 10'h052, 10'h01a, 10'h029, 10'h051, 10'h01f,
        10'h02a, 10'h2ea, 10'h052, 10'h00c, 10'h2e0, 10'h2e0, 10'h052,
        10'h00c};
    rtx_exec i_rtx_exec (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_exec(i_exec), .i_opcode(i_opcode), .i_carry_flag(i_carry_flag),
        .i_z_ld(i_z_ld), .i_z_we(i_z_we), .o_acc(o_acc), .o_b(o_b),
        .o_x(o_x), .o_y(o_y), .o_e(o_e), .o_d(o_d), .o_z(o_z),
        .o_carry_flag(o_carry_flag), .o_skip(o_skip));
    initial forever #2 i_core_clk = ~i_core_clk;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic chk_all();
        if (!$isunknown(m_a)) chk("acc", {4'h0, o_acc}, {4'h0, m_a});
        chk("b", {4'h0, o_b}, {4'h0, m_b});
        chk("x", {4'h0, o_x}, {4'h0, m_x});
        chk("y", {4'h0, o_y}, {4'h0, m_y});
        chk("e", o_e, m_e);
        chk("d", {5'h00, o_d}, {5'h00, m_d});
        chk("z", {6'h00, o_z}, {6'h00, m_z});
        chk("skip", {7'h00, o_skip}, {7'h00, m_s});
        chk("carry", {7'h00, o_carry_flag}, {7'h00, i_carry_flag});
    endtask : chk_all
    task automatic model(input logic [9:0] op);
        logic [9:0] ad;
        logic [3:0] t;
        ad = {m_z, m_x, m_y};
        m_s = 1'b0;
        if (op[9:4] == RTX_SWAP_INC_HI) begin
            t = m_ram[ad];
            m_ram[ad] = m_a;
            m_a = t;
            m_x = m_x ^ op[3:0];
            m_y = m_y + 4'h1;
            m_s = (m_y == 4'h0);
        end else case (op)
            OP_MOVE_B_INTO_ACC: m_a = m_b;
            OP_MOVE_ACC_INTO_B: m_b = m_a;
            OP_MOVE_Y_INTO_ACC: m_a = m_y;
            OP_MOVE_ACC_INTO_Y: m_y = m_a;
            OP_LOAD_WIDE_FROM_PAIR: m_e = {m_b, m_a};
            OP_SPLIT_WIDE_INTO_PAIR: {m_b, m_a} = m_e;
            OP_LOAD_TABLE_PTR: m_d = m_a[2:0];
            OP_READ_TABLE_PTR: m_a = {1'b0, m_d};
            OP_MOVE_FILE_PTR: m_a = m_x;
            OP_READ_BANK: m_a = {2'h0, m_z};
            default: m_s = 1'b0;
        endcase
    endtask : model
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    initial begin
        repeat (400) @(posedge i_core_clk);
        fails++;
        results();
    end
    initial begin
        {m_a, m_b, m_x, m_y, m_e, m_d, m_z, m_s} = '0;
        repeat (20) @(posedge i_core_clk);
        #1 chk_all();
        @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        i_z_we <= 1'b1;
        i_z_ld <= 2'h3;
        @(posedge i_core_clk);
        i_z_we <= 1'b0;
        m_z = 2'h3;
        for (int i = 0; i <= 18; i++) begin
            @(posedge i_core_clk);
            i_exec <= (i < 18);
            i_opcode <= (i < 18) ? rows[i] : OP_MOVE_B_INTO_ACC;
            i_carry_flag <= i[0];
            #1;
            if (i > 0) chk_all();
            if (i < 18) model(rows[i]);
        end
        // idle exec with a live opcode must leave everything alone
        @(posedge i_core_clk);
        #1 chk_all();
        @(posedge i_core_clk);
        i_exec <= 1'b1;
        i_opcode <= 10'h3ff;
        @(posedge i_core_clk);
        i_exec <= 1'b0;
        #1 chk_all();
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        // two low edges, so no idle check straddles the release
        @(posedge i_core_clk);
        @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        {m_a, m_b, m_x, m_y, m_e, m_d, m_z, m_s} = '0;
        #1 chk_all();
        @(posedge i_core_clk);
        #1 chk_all();
        results();
    end
endmodule : rtx_exec_bench

/* File: src/rtx_exec.sv */
// Purpose: decode and execute register transfers and the exchange-
//          increment-skip instruction of a 4-bit core
// Assumes: one instruction per cycle when i_exec is high
// Notes: fetch acts on o_skip; carry is passed through untouched
`timescale 1ns/1ps
module rtx_exec
    import rtx_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_exec,
    input wire logic [RTX_OPW-1:0] i_opcode,
    input wire logic i_carry_flag,
    input wire logic [1:0] i_z_ld,
    input wire logic i_z_we,
    output logic [RTX_NW-1:0] o_acc,
    output logic [RTX_NW-1:0] o_b,
    output logic [RTX_NW-1:0] o_x,
    output logic [RTX_NW-1:0] o_y,
    output logic [RTX_EW-1:0] o_e,
    output logic [RTX_DW-1:0] o_d,
    output logic [RTX_ZW-1:0] o_z,
    output logic o_carry_flag,
    output logic o_skip
);
    logic [RTX_NW-1:0] acc_ff, b_ff, x_ff, y_ff;
    logic [RTX_EW-1:0] e_ff;
    logic [RTX_DW-1:0] d_ff;
    logic [RTX_ZW-1:0] z_ff;
    logic skip_ff;
    logic [RTX_NW-1:0] ram_mem [RTX_RAM_DEPTH];

    // ram pointer is bank, file and digit concatenated
    wire [RTX_RAM_AW-1:0] ram_pointer = {z_ff, x_ff, y_ff};
    wire [RTX_NW-1:0] ram_rd = ram_mem[ram_pointer];
    wire [RTX_NW-1:0] imm_j = i_opcode[RTX_NW-1:0];

    function automatic logic is_op(input logic [RTX_OPW-1:0] op,
                                   input logic [RTX_OPW-1:0] code);
        is_op = i_exec && (op == code);
    endfunction : is_op

    wire swap_mem_acc_inc_skip = i_exec &&
        (i_opcode[RTX_OPW-1:RTX_NW] == RTX_SWAP_INC_HI);
    wire move_b_into_acc = is_op(i_opcode, OP_MOVE_B_INTO_ACC);
    wire move_acc_into_b = is_op(i_opcode, OP_MOVE_ACC_INTO_B);
    wire move_y_into_acc = is_op(i_opcode, OP_MOVE_Y_INTO_ACC);
    wire move_acc_into_y = is_op(i_opcode, OP_MOVE_ACC_INTO_Y);
    wire load_wide_from_pair = is_op(i_opcode, OP_LOAD_WIDE_FROM_PAIR);
    wire split_wide_into_pair = is_op(i_opcode, OP_SPLIT_WIDE_INTO_PAIR);
    wire load_table_ptr_from_acc = is_op(i_opcode, OP_LOAD_TABLE_PTR);
    wire read_table_ptr_to_acc = is_op(i_opcode, OP_READ_TABLE_PTR);
    wire move_file_ptr_into_acc = is_op(i_opcode, OP_MOVE_FILE_PTR);
    wire read_bank_to_acc = is_op(i_opcode, OP_READ_BANK);

    wire [RTX_NW-1:0] y_inc = y_ff + RTX_NIB_ONE;

    // any decoded opcode of this group; others are refused without effect
    wire known_op = swap_mem_acc_inc_skip || move_b_into_acc ||
        move_acc_into_b || move_y_into_acc || move_acc_into_y ||
        load_wide_from_pair || split_wide_into_pair ||
        load_table_ptr_from_acc || read_table_ptr_to_acc ||
        move_file_ptr_into_acc || read_bank_to_acc;

    // accumulator source select; one hot by opcode decode
    wire [RTX_NW-1:0] nxt_acc =
        swap_mem_acc_inc_skip ? ram_rd :
        move_b_into_acc ? b_ff :
        move_y_into_acc ? y_ff :
        move_file_ptr_into_acc ? x_ff :
        split_wide_into_pair ? e_ff[RTX_NW-1:0] :
        read_table_ptr_to_acc ? {1'b0, d_ff} :
        read_bank_to_acc ? {2'b00, z_ff} :
        acc_ff;
    wire [RTX_NW-1:0] nxt_b = move_acc_into_b ? acc_ff :
        split_wide_into_pair ? e_ff[RTX_EW-1:RTX_NW] : b_ff;
    wire [RTX_NW-1:0] nxt_x = swap_mem_acc_inc_skip ?
        (x_ff ^ imm_j) : x_ff;
    wire [RTX_NW-1:0] nxt_y = swap_mem_acc_inc_skip ? y_inc :
        move_acc_into_y ? acc_ff : y_ff;
    wire [RTX_EW-1:0] nxt_e = load_wide_from_pair ?
        {b_ff, acc_ff} : e_ff;
    wire [RTX_DW-1:0] nxt_d = load_table_ptr_from_acc ?
        acc_ff[RTX_DW-1:0] : d_ff;
    wire [RTX_ZW-1:0] nxt_z = i_z_we ? i_z_ld : z_ff;
    wire nxt_skip = swap_mem_acc_inc_skip && (y_inc == RTX_NIB_ZERO);

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            acc_ff <= RTX_NIB_ZERO;
            b_ff <= RTX_NIB_ZERO;
            x_ff <= RTX_NIB_ZERO;
            y_ff <= RTX_NIB_ZERO;
            e_ff <= RTX_E_RST;
            d_ff <= RTX_D_RST;
            z_ff <= RTX_Z_RST;
            skip_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            b_ff <= nxt_b;
            x_ff <= nxt_x;
            y_ff <= nxt_y;
            e_ff <= nxt_e;
            d_ff <= nxt_d;
            z_ff <= nxt_z;
            skip_ff <= nxt_skip;
        end
    end

    // ram has no reset; write old accumulator in the swap cycle
    always_ff @(posedge i_core_clk) begin
        if (swap_mem_acc_inc_skip) begin
            ram_mem[ram_pointer] <= acc_ff;
        end
    end

    assign o_acc = acc_ff;
    assign o_b = b_ff;
    assign o_x = x_ff;
    assign o_y = y_ff;
    assign o_e = e_ff;
    assign o_d = d_ff;
    assign o_z = z_ff;
    // carry has no writer in this group, so it passes straight through
    assign o_carry_flag = i_carry_flag;
    assign o_skip = skip_ff;

    // checks look at the registered outputs one cycle after the decode;
    // ram nibbles start unknown, so ram data is matched case-exactly
    swap_exch_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) swap_mem_acc_inc_skip |=>
        o_acc === $past(ram_rd))
        else $error("swap did not load ram nibble");
    ram_write_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) swap_mem_acc_inc_skip |=>
        ram_mem[$past(ram_pointer)] === $past(acc_ff))
        else $error("swap did not store old accumulator");
    xor_file_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) swap_mem_acc_inc_skip |=>
        o_x == ($past(x_ff) ^ $past(imm_j)))
        else $error("x xor wrong");
    skip_wrap_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) swap_mem_acc_inc_skip |=>
        (o_skip == (o_y == RTX_NIB_ZERO)) &&
        o_y == $past(y_ff) + RTX_NIB_ONE)
        else $error("y increment or skip wrong");
    skip_only_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) !swap_mem_acc_inc_skip |=>
        !o_skip)
        else $error("skip raised without exchange");

    acc_to_b_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) move_acc_into_b |=>
        o_b == $past(acc_ff))
        else $error("b not loaded from acc");
    b_to_acc_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) move_b_into_acc |=>
        o_acc == $past(b_ff))
        else $error("acc not loaded from b");
    y_to_acc_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) move_y_into_acc |=>
        o_acc == $past(y_ff))
        else $error("acc not loaded from y");
    acc_to_y_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) move_acc_into_y |=>
        o_y == $past(acc_ff))
        else $error("y not loaded from acc");
    x_to_acc_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) move_file_ptr_into_acc |=>
        o_acc == $past(x_ff))
        else $error("acc not loaded from x");
    d_load_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) load_table_ptr_from_acc |=>
        o_d == $past(acc_ff[RTX_DW-1:0]))
        else $error("d not loaded from acc");

    wide_load_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) load_wide_from_pair |=>
        o_e == {$past(b_ff), $past(acc_ff)})
        else $error("e load wrong");
    wide_split_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) split_wide_into_pair |=>
        {o_b, o_acc} == $past(e_ff))
        else $error("e split wrong");
    table_read_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) read_table_ptr_to_acc |=>
        o_acc == {1'b0, $past(d_ff)})
        else $error("d read wrong");
    bank_read_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) read_bank_to_acc |=>
        o_acc == {2'b00, $past(z_ff)})
        else $error("z read wrong");

    // nothing outside the named destinations may move: checked when idle, on unknown opcodes and in the exchange; the wide load checks acc and b only
    hold_idle_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) !i_exec && !i_z_we |=>
        $stable(o_acc) && $stable(o_b) && $stable(o_x) && $stable(o_y) &&
        $stable(o_e) && $stable(o_d) && !o_skip)
        else $error("state moved");
    refuse_op_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) i_exec && !known_op && !i_z_we |=>
        $stable(o_acc) && $stable(o_b) && $stable(o_x) && $stable(o_y) &&
        $stable(o_e) && $stable(o_d) && !o_skip)
        else $error("unknown opcode changed state");
    swap_keep_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) swap_mem_acc_inc_skip && !i_z_we |=>
        $stable(o_b) && $stable(o_e) && $stable(o_d) && $stable(o_z))
        else $error("exchange touched other registers");
    x_keep_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) !swap_mem_acc_inc_skip |=>
        $stable(o_x))
        else $error("x changed outside exchange");
    wide_keep_a: assert property (@(posedge i_core_clk)
        disable iff (!i_reset_n) load_wide_from_pair |=>
        $stable(o_acc) && $stable(o_b))
        else $error("wide load touched acc or b");

    // no disable here: this one watches the reset itself
    reset_clear_a: assert property (@(posedge i_core_clk)
        !i_reset_n |=> o_acc == RTX_NIB_ZERO && o_b == RTX_NIB_ZERO &&
        o_x == RTX_NIB_ZERO && o_y == RTX_NIB_ZERO && o_e == RTX_E_RST &&
        o_d == RTX_D_RST && o_z == RTX_Z_RST && !o_skip)
        else $error("reset left state behind");
endmodule : rtx_exec

/* File: src/rtx_pkg.sv */
// Purpose: constants for the register transfer execute block
// Assumes: 10-bit instruction words, 4-bit data path
// Notes: opcodes are full 10-bit codes except the exchange group
package rtx_pkg;
    localparam int RTX_OPW = 10;
    localparam int RTX_NW = 4;
    localparam int RTX_EW = 8;
    localparam int RTX_DW = 3;
    localparam int RTX_ZW = 2;
    localparam int RTX_RAM_DEPTH = 1024;
    localparam int RTX_RAM_AW = 10;
    // exchange group: upper six bits match, low four carry j
    localparam logic [5:0] RTX_SWAP_INC_HI = 6'h2e;
    localparam logic [9:0] OP_MOVE_B_INTO_ACC = 10'h01e;
    localparam logic [9:0] OP_MOVE_ACC_INTO_B = 10'h00e;
    localparam logic [9:0] OP_MOVE_Y_INTO_ACC = 10'h01f;
    localparam logic [9:0] OP_MOVE_ACC_INTO_Y = 10'h00c;
    localparam logic [9:0] OP_LOAD_WIDE_FROM_PAIR = 10'h01a;
    localparam logic [9:0] OP_SPLIT_WIDE_INTO_PAIR = 10'h02a;
    localparam logic [9:0] OP_LOAD_TABLE_PTR = 10'h029;
    localparam logic [9:0] OP_READ_TABLE_PTR = 10'h051;
    localparam logic [9:0] OP_MOVE_FILE_PTR = 10'h052;
    localparam logic [9:0] OP_READ_BANK = 10'h053;
    localparam logic [3:0] RTX_NIB_ZERO = 4'h0;
    localparam logic [3:0] RTX_NIB_ONE = 4'h1;
    localparam logic [7:0] RTX_E_RST = 8'h00;
    localparam logic [2:0] RTX_D_RST = 3'h0;
    localparam logic [1:0] RTX_Z_RST = 2'h0;
endpackage : rtx_pkg
